/* design/pst_pkg.sv */
// Purpose: constants shared by the system time and timestamp unit
// Assumes: 32-bit APB, one clock domain at 100 MHz
// Notes:   sub-second field rolls over at 2^31 (binary format)
package pst_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_ADDEND  = 8'h04;
	localparam logic [7:0] OFS_UPDSEC  = 8'h08;
	localparam logic [7:0] OFS_UPDSUB  = 8'h0C;
	localparam logic [7:0] OFS_TIMESEC = 8'h10;
	localparam logic [7:0] OFS_TIMESUB = 8'h14;
	localparam logic [7:0] OFS_INCR    = 8'h18;
	localparam logic [7:0] OFS_STAT    = 8'h1C;
	// control field positions
	localparam int CTL_FINE   = 0;
	localparam int CTL_INIT   = 1;
	localparam int CTL_UPD    = 2;
	localparam int CTL_SUB    = 3;
	localparam int CTL_CLKSEL = 4;
	// status field positions
	localparam int ST_TXPEND = 0;
	localparam int ST_RXPEND = 1;
	localparam int ST_TXDROP = 2;
	localparam int ST_RXDROP = 3;
	// reset values and sub-second rollover point
	localparam logic [31:0] SUBINC_RST = 32'h0000002B;
	localparam logic [31:0] ADDEND_RST = 32'h00000000;
	localparam logic [31:0] SUB_ROLL   = 32'h80000000;
	// timing: one clock serves as both PHY and PTP clock here
	localparam int CLK_PERIOD_NS = 10;
	localparam int RES_NS        = 20;
	localparam int PHY_GAP_CLKS  = 4;
	localparam int PTP_GAP_CLKS  = 3;
	localparam int GAP_CYC       = PHY_GAP_CLKS + PTP_GAP_CLKS;
endpackage

/* design/pst_cap_if.sv */
// Purpose: link between the time unit and one capture channel
// Assumes: single clock domain
// Notes:   sysTime is the live 64-bit reference time
`timescale 1ns/100ps
`default_nettype none
interface pst_cap_if;
	logic        sfd;
	logic        enable;
	logic        take;
	logic [63:0] sysTime;
	logic        tsValid;
	logic [63:0] tsData;
	logic        dropped;
	modport unit (input sfd, enable, take, sysTime,
		output tsValid, tsData, dropped);
	modport host (output sfd, enable, take, sysTime,
		input tsValid, tsData, dropped);
endinterface
`default_nettype wire

/* design/pst_capture.sv */
// Purpose: one timestamp capture channel with hold-off and handshake
// Assumes: sfd is a one-cycle pulse synchronous to clk
// Notes:   a held stamp is never overwritten; later stamps are dropped
`timescale 1ns/100ps
`default_nettype none
module pst_capture
	import pst_pkg::*;
#(
	parameter int GAP = GAP_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// channel
	pst_cap_if.unit   cap
);
	localparam int CW = $clog2(GAP + 1);

	logic [CW-1:0] gapCnt_q;
	logic          tsValid_q;
	logic [63:0]   tsData_q;
	wire           gapFree;
	wire           accept;

	// a stamp is taken only outside the hold-off and with room to keep it
	assign gapFree = (gapCnt_q == '0);
	assign accept = cap.sfd & cap.enable & gapFree & ~tsValid_q;
	assign cap.dropped = cap.sfd & cap.enable & ~accept;
	assign cap.tsValid = tsValid_q;
	assign cap.tsData = tsData_q;

	// hold-off counter restarts at each accepted stamp
	always_ff @(posedge clk) begin
		if (srst)
			gapCnt_q <= '0;
		else if (accept)
			gapCnt_q <= CW'(GAP - 1);
		else if (!gapFree)
			gapCnt_q <= gapCnt_q - 1'b1;
	end

	// stamp held whole until taken, so no torn 64-bit value escapes
	always_ff @(posedge clk) begin
		if (srst) begin
			tsValid_q <= 1'b0;
			tsData_q  <= '0;
		end else if (accept) begin
			tsValid_q <= 1'b1;
			tsData_q  <= cap.sysTime;
		end else if (cap.take) begin
			tsValid_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence sAccept;
		accept;
	endsequence
	sequence sQuiet;
		(!accept) [*6];
	endsequence

	a_stamp_value: assert property (sAccept |=> tsValid_q && tsData_q == $past(cap.sysTime))
		else $error("stamp not sampled at delimiter");
	a_gap_holdoff: assert property (sAccept |=> sQuiet)
		else $error("stamp taken inside hold-off gap");
	a_hold_stable: assert property (tsValid_q && !cap.take |=> tsValid_q && $stable(tsData_q))
		else $error("held stamp changed before take");
endmodule
`default_nettype wire

/* design/pst_time_unit.sv */
// Purpose: 64-bit system time with coarse/fine correction and stamps
// Assumes: reference clock inputs are levels synchronous to clk
// Notes:   each rising level of the chosen source is one PTP tick
//
// Notes on behaviour
// - 64-bit time from reference clock feeds stamps
// - time ticks on selected reference clock source
// - init request loads time from update registers
// - update request adds or subtracts offset once
// - fine mode: addend accumulates, carry increments time
// - accumulator and addend are 32 bits wide
// - each increment adds constant to sub-seconds
// - transmit stamp taken at outgoing delimiter
// - transmit stamp only when descriptor bit set
// - transmit stamp returned in descriptor words two, three
// - every received frame gets a stamp; here a frame arriving while a stamp is still held is dropped
// - receive stamp written to last descriptor only
// - transmit stamp within two PTP clocks
// - pulse-per-second output derived from system time
// - receive stamp within three PHY plus two PTP
// - capture too soon after previous is skipped
`timescale 1ns/100ps
`default_nettype none
module pst_time_unit
	import pst_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int GAP    = GAP_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// reference clock sources
	input  wire logic              primaryOscillatorClock,
	input  wire logic              fabricToSystemTimeClock,
	// transmit path and descriptor write-back
	input  wire logic              txSfd,
	input  wire logic              txTsRequest,
	input  wire logic              txDescWrite,
	output logic                   txDescTsWrite,
	output logic [31:0]            txDescriptorWordTwo,
	output logic [31:0]            txDescriptorWordThree,
	// receive path and descriptor write-back
	input  wire logic              rxSfd,
	input  wire logic              rxDescWrite,
	input  wire logic              rxDescLast,
	output logic                   rxDescTsWrite,
	output logic [31:0]            rxDescTsLow,
	output logic [31:0]            rxDescTsHigh,
	// fabric monitor
	output logic                   ppsOut
);
	// software-visible state
	logic        fine_q;
	logic        subtract_q;
	logic        clkSel_q;
	logic        initPend_q;
	logic        updPend_q;
	logic [31:0] addend_q;
	logic [31:0] updSec_q;
	logic [31:0] updSub_q;
	logic [31:0] subInc_q;
	logic        txDrop_q;
	logic        rxDrop_q;
	logic [31:0] prdata_q;
	// time state
	logic        refPrev_q;
	logic [31:0] acc_q;
	logic [31:0] sec_q;
	logic [31:0] sub_q;
	logic        pps_q;

	pst_cap_if txCap ();
	pst_cap_if rxCap ();

	// apb decode
	wire [7:0] regOfs = 8'(paddr);
	wire       setupPh = psel & ~penable;
	wire       accessPh = psel & penable;
	wire       mapped = (regOfs[1:0] == 2'b00) && (regOfs <= OFS_STAT);
	wire       wrEn = accessPh & pwrite & mapped;
	wire       wrCtrl = wrEn & (regOfs == OFS_CTRL);
	wire       wrStat = wrEn & (regOfs == OFS_STAT);
	assign pready = 1'b1;
	assign pslverr = accessPh & ~mapped; // unmapped: error, no effect
	assign prdata = prdata_q;

	// read mux; reserved bits read zero
	wire [31:0] ctrlRd = {27'h0, clkSel_q, subtract_q, updPend_q,
		initPend_q, fine_q};
	wire [31:0] statRd = {28'h0, rxDrop_q, txDrop_q, rxCap.tsValid,
		txCap.tsValid};
	logic [31:0] rdMux;
	always_comb begin
		case (regOfs)
			OFS_CTRL:    rdMux = ctrlRd;
			OFS_ADDEND:  rdMux = addend_q;
			OFS_UPDSEC:  rdMux = updSec_q;
			OFS_UPDSUB:  rdMux = updSub_q;
			OFS_TIMESEC: rdMux = sec_q;
			OFS_TIMESUB: rdMux = sub_q;
			OFS_INCR:    rdMux = subInc_q;
			OFS_STAT:    rdMux = statRd;
			default:     rdMux = 32'h00000000;
		endcase
	end

	// read data latched in setup so it is a flop during access
	always_ff @(posedge clk) begin
		if (srst)
			prdata_q <= '0;
		else if (setupPh)
			prdata_q <= pwrite ? 32'h00000000 : rdMux;
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			fine_q     <= 1'b0;
			subtract_q <= 1'b0;
			clkSel_q   <= 1'b0;
			addend_q   <= ADDEND_RST;
			updSec_q   <= '0;
			updSub_q   <= '0;
			subInc_q   <= SUBINC_RST;
		end else if (wrEn) begin
			case (regOfs)
				OFS_CTRL: begin
					fine_q     <= pwdata[CTL_FINE];
					subtract_q <= pwdata[CTL_SUB];
					clkSel_q   <= pwdata[CTL_CLKSEL];
				end
				OFS_ADDEND: addend_q <= pwdata;
				OFS_UPDSEC: updSec_q <= pwdata;
				OFS_UPDSUB: updSub_q <= pwdata;
				OFS_INCR:   subInc_q <= pwdata;
				default: ;
			endcase
		end
	end

	// one-shot correction commands, cleared once applied
	always_ff @(posedge clk) begin
		if (srst) begin
			initPend_q <= 1'b0;
			updPend_q  <= 1'b0;
		end else begin
			initPend_q <= wrCtrl & pwdata[CTL_INIT];
			updPend_q  <= wrCtrl & pwdata[CTL_UPD];
		end
	end

	// sticky drop flags, write one to clear; a new drop wins
	always_ff @(posedge clk) begin
		if (srst) begin
			txDrop_q <= 1'b0;
			rxDrop_q <= 1'b0;
		end else begin
			txDrop_q <= (txDrop_q & ~(wrStat & pwdata[ST_TXDROP]))
				| txCap.dropped;
			rxDrop_q <= (rxDrop_q & ~(wrStat & pwdata[ST_RXDROP]))
				| rxCap.dropped;
		end
	end

	// reference tick: rising level of the selected source
	wire refLvl = clkSel_q ? fabricToSystemTimeClock : primaryOscillatorClock;
	wire refTick = refLvl & ~refPrev_q;
	always_ff @(posedge clk) begin
		if (srst)
			refPrev_q <= 1'b0;
		else
			refPrev_q <= refLvl;
	end

	// fine accumulator; its carry is the increment pulse
	wire [32:0] accSum = {1'b0, acc_q} + {1'b0, addend_q};
	wire        accCarry = accSum[32];
	wire        incPulse = refTick & (fine_q ? accCarry : 1'b1);
	always_ff @(posedge clk) begin
		if (srst)
			acc_q <= '0;
		else if (refTick && fine_q)
			acc_q <= accSum[31:0];
	end

	// regular step with rollover into seconds
	wire [32:0] subAdv = {1'b0, sub_q} + {1'b0, subInc_q};
	wire        subRoll = subAdv >= {1'b0, SUB_ROLL};
	wire [31:0] subStep = subRoll ? subAdv[31:0] - SUB_ROLL : subAdv[31:0];

	// coarse offset; software keeps the offset sub-seconds below rollover
	wire [32:0] addSub = {1'b0, sub_q} + {1'b0, updSub_q};
	wire        addCarry = addSub >= {1'b0, SUB_ROLL};
	wire [32:0] difSub = {1'b0, sub_q} - {1'b0, updSub_q};
	wire        borrow = difSub[32];
	wire [31:0] offSubAdd = addCarry ? addSub[31:0] - SUB_ROLL : addSub[31:0];
	wire [31:0] offSubDif = borrow ? difSub[31:0] + SUB_ROLL : difSub[31:0];
	wire [31:0] offSub = subtract_q ? offSubDif : offSubAdd;
	wire [31:0] offSec = subtract_q ? sec_q - updSec_q - {31'h0, borrow}
		: sec_q + updSec_q + {31'h0, addCarry};

	// time register; a correction takes priority over a tick that cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			sec_q <= '0;
			sub_q <= '0;
		end else if (initPend_q) begin
			sec_q <= updSec_q;
			sub_q <= updSub_q;
		end else if (updPend_q) begin
			sec_q <= offSec;
			sub_q <= offSub;
		end else if (incPulse) begin
			sec_q <= sec_q + {31'h0, subRoll};
			sub_q <= subStep;
		end
	end

	// high during the first half of each second
	always_ff @(posedge clk) begin
		if (srst)
			pps_q <= 1'b0;
		else
			pps_q <= ~sub_q[30];
	end
	assign ppsOut = pps_q;

	// capture channels share the live 64-bit time
	assign txCap.sysTime = {sec_q, sub_q};
	assign rxCap.sysTime = {sec_q, sub_q};
	assign txCap.sfd = txSfd;
	assign txCap.enable = txTsRequest;
	assign rxCap.sfd = rxSfd;
	assign rxCap.enable = 1'b1;
	// write-back only when DMA stores this frame's descriptor
	assign txDescTsWrite = txDescWrite & txCap.tsValid;
	assign txCap.take = txDescTsWrite;
	assign rxDescTsWrite = rxDescWrite & rxDescLast & rxCap.tsValid;
	assign rxCap.take = rxDescTsWrite;
	assign txDescriptorWordTwo = txCap.tsData[31:0];
	assign txDescriptorWordThree = txCap.tsData[63:32];
	assign rxDescTsLow = rxCap.tsData[31:0];
	assign rxDescTsHigh = rxCap.tsData[63:32];

	pst_capture #(
		.GAP (GAP)
	) u_txCapture (
		.clk  (clk),
		.srst (srst),
		.cap  (txCap)
	);

	pst_capture #(
		.GAP (GAP)
	) u_rxCapture (
		.clk  (clk),
		.srst (srst),
		.cap  (rxCap)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence sInitReq;
		wrCtrl && pwdata[CTL_INIT];
	endsequence

	a_init_load: assert property (sInitReq ##1 1'b1 |=> sec_q == $past(updSec_q, 2) && sub_q == $past(updSub_q, 2))
		else $error("init did not load update value");
	a_fine_hold: assert property (refTick && fine_q && !accCarry && !initPend_q && !updPend_q |=> $stable(sub_q) && $stable(sec_q))
		else $error("time moved without accumulator carry");
	a_sub_step: assert property (incPulse && !subRoll && !initPend_q && !updPend_q |=> sub_q == $past(sub_q) + $past(subInc_q) && $stable(sec_q))
		else $error("sub-second step wrong");
	a_sec_roll: assert property (incPulse && subRoll && !initPend_q && !updPend_q |=> sec_q == $past(sec_q) + 32'h00000001)
		else $error("seconds did not advance on rollover");
	a_coarse_add: assert property (updPend_q && !initPend_q && !subtract_q && updSub_q == 32'h0 |=> sub_q == $past(sub_q) && sec_q == $past(sec_q) + $past(updSec_q))
		else $error("coarse add wrong");
	a_rx_last: assert property (rxDescTsWrite |-> rxDescLast ##1 !rxCap.tsValid)
		else $error("rx stamp outside last descriptor");
	a_tx_flag: assert property (txSfd && !txTsRequest && !txCap.tsValid |=> !txCap.tsValid)
		else $error("unflagged frame stamped");
	a_pps_track: assert property (!sub_q[30] |=> ppsOut)
		else $error("pps not following time");
	// time may only move on a tick or a software correction
	a_clk_hold: assert property (!refTick && !initPend_q && !updPend_q
		|=> $stable(sub_q) && $stable(sec_q))
		else $error("time moved without a reference tick");
	a_upd_single: assert property (updPend_q |=> !updPend_q)
		else $error("coarse update applied twice");
	a_tx_return: assert property (txDescWrite && txCap.tsValid
		|=> !txCap.tsValid)
		else $error("tx stamp kept after write-back");
endmodule
`default_nettype wire

/* testbench/pst_mac_model.sv */
// Purpose: MAC path and descriptor DMA stand-in for the time unit
// Assumes: one clock; delimiters and write-backs are one-cycle pulses
// Notes:   qualifiers carry inverted junk outside their pulse
`timescale 1ns/100ps
`default_nettype none
module pst_mac_model (
	// clock
	input  wire logic        clk,
	// transmit side
	output logic             txSfd,
	output logic             txTsRequest,
	output logic             txDescWrite,
	input  wire logic        txDescTsWrite,
	input  wire logic [31:0] txDescriptorWordTwo,
	input  wire logic [31:0] txDescriptorWordThree,
	// receive side
	output logic             rxSfd,
	output logic             rxDescWrite,
	output logic             rxDescLast,
	input  wire logic        rxDescTsWrite,
	input  wire logic [31:0] rxDescTsLow,
	input  wire logic [31:0] rxDescTsHigh
);
	// quiet at time zero
	initial begin
		txSfd       = 1'b0;
		txTsRequest = 1'b1;
		txDescWrite = 1'b0;
		rxSfd       = 1'b0;
		rxDescWrite = 1'b0;
		rxDescLast  = 1'b1;
	end
	// one tx delimiter, stamp bit as software set it
	task automatic send_tx(input logic req);
		@(posedge clk);
		txSfd       <= 1'b1;
		txTsRequest <= req;
		@(posedge clk);
		txSfd       <= 1'b0;
		txTsRequest <= ~req; // released: no stale copy
	endtask
	// tx write-back, looked at mid-cycle so the held flag is settled
	task automatic back_tx(output logic got, output logic [63:0] ts);
		@(posedge clk);
		txDescWrite <= 1'b1;
		@(negedge clk);
		got = txDescTsWrite;
		ts  = {txDescriptorWordThree, txDescriptorWordTwo};
		@(posedge clk);
		txDescWrite <= 1'b0;
	endtask
	// one rx delimiter
	task automatic send_rx;
		@(posedge clk);
		rxSfd <= 1'b1;
		@(posedge clk);
		rxSfd <= 1'b0;
	endtask
	// rx descriptor write-back, last or not
	task automatic back_rx(input logic last, output logic got,
		output logic [63:0] ts);
		@(posedge clk);
		rxDescWrite <= 1'b1;
		rxDescLast  <= last;
		@(negedge clk);
		got = rxDescTsWrite;
		ts  = {rxDescTsHigh, rxDescTsLow};
		@(posedge clk);
		rxDescWrite <= 1'b0;
		rxDescLast  <= ~last;
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for the system time unit
// Assumes: ref clocks frozen except in ticks, so time is exact
// Notes:   registers reached over APB, one idle cycle between
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pst_pkg::*;
	localparam logic [31:0] C_INI = 32'h1 << CTL_INIT;
	localparam logic [31:0] C_UPD = 32'h1 << CTL_UPD;
	localparam logic [31:0] C_SUB = 32'h1 << CTL_SUB;
	localparam logic [31:0] C_FAB = 32'h1 << CTL_CLKSEL;
	localparam logic [63:0] TS    = 64'h000000094000001B;
	localparam logic [31:0] S_TXP = 32'h1 << ST_TXPEND;
	localparam logic [31:0] S_TXD = 32'h1 << ST_TXDROP;
	// design signals
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, txW2, txW3, rxLo, rxHi;
	logic refPrim, refFab, ppsOut;
	logic txSfd, txReq, txWb, txTsWr, rxSfd, rxWb, rxLast, rxTsWr;
	int errTotal, checkCount;
	pst_time_unit dut (.clk(clk), .srst(srst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .primaryOscillatorClock(refPrim),
		.fabricToSystemTimeClock(refFab), .txSfd(txSfd),
		.txTsRequest(txReq), .txDescWrite(txWb),
		.txDescTsWrite(txTsWr), .txDescriptorWordTwo(txW2),
		.txDescriptorWordThree(txW3), .rxSfd(rxSfd),
		.rxDescWrite(rxWb), .rxDescLast(rxLast),
		.rxDescTsWrite(rxTsWr), .rxDescTsLow(rxLo),
		.rxDescTsHigh(rxHi), .ppsOut(ppsOut));
	pst_mac_model mac (.clk(clk), .txSfd(txSfd), .txTsRequest(txReq),
		.txDescWrite(txWb), .txDescTsWrite(txTsWr),
		.txDescriptorWordTwo(txW2), .txDescriptorWordThree(txW3),
		.rxSfd(rxSfd), .rxDescWrite(rxWb), .rxDescLast(rxLast),
		.rxDescTsWrite(rxTsWr), .rxDescTsLow(rxLo),
		.rxDescTsHigh(rxHi));
	// 100 MHz clock
	always #5 clk = ~clk;
	task automatic chk(input logic [63:0] g, input logic [63:0] e,
		input string m);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("ERROR at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	// one APB transfer; waits on pready, the watchdog bounds a hang
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chk(n, 1, "wait states"); // slave inserts no wait state
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
		chk(e, 1'b0, "write error");
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		chk(r, x, "read data");
		chk(e, 1'b0, "slave error");
	endtask
	// control write, then let init/update land
	task automatic ctl(input logic [31:0] v);
		wr(OFS_CTRL, v);
		repeat (3) @(posedge clk);
	endtask
	task automatic tm(input logic [31:0] s, input logic [31:0] u);
		rdc(OFS_TIMESEC, s);
		rdc(OFS_TIMESUB, u);
	endtask
	// one rising level on a reference source
	task automatic tick(input logic fab);
		@(posedge clk);
		if (fab)
			refFab <= 1'b1;
		else
			refPrim <= 1'b1;
		@(posedge clk);
		refFab  <= 1'b0;
		refPrim <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_ADDEND, ADDEND_RST);
		rdc(OFS_INCR, SUBINC_RST);
		rdc(OFS_STAT, 32'h0);
		wr(OFS_TIMESEC, 32'hFFFFFFFF);
		tm(32'h0, 32'h0);
		apb(8'h20, 1'b0, 32'h0, r, e);
		chk({r, e}, 33'h1, "unmapped read");
		@(negedge clk);
		chk(ppsOut, 1'b1, "pps after reset");
		$display("register reset test done");
	endtask
	task automatic t_load;
		wr(OFS_UPDSEC, 32'h5);
		wr(OFS_UPDSUB, 32'h7FFFFFF0);
		ctl(C_INI);
		tm(32'h5, 32'h7FFFFFF0);
		tick(1'b0);
		tm(32'h6, 32'h1B);
		ctl(C_FAB);
		tick(1'b0);
		tm(32'h6, 32'h1B);
		tick(1'b1);
		tm(32'h6, 32'h46);
		$display("load and tick test done");
	endtask
	task automatic t_coarse;
		wr(OFS_UPDSEC, 32'h1);
		wr(OFS_UPDSUB, 32'h10);
		ctl(C_FAB | C_UPD);
		tm(32'h7, 32'h56);
		ctl(C_FAB | C_UPD | C_SUB);
		tm(32'h6, 32'h46);
		wr(OFS_UPDSUB, 32'h50);
		ctl(C_FAB | C_UPD | C_SUB);
		tm(32'h4, 32'h7FFFFFF6);
		wr(OFS_UPDSUB, 32'h0);
		ctl(C_FAB | C_UPD);
		tm(32'h5, 32'h7FFFFFF6);
		ctl(C_FAB | C_UPD | C_SUB);
		tm(32'h4, 32'h7FFFFFF6);
		$display("coarse test done");
	endtask
	// half-scale addend: one carry every second tick
	task automatic t_fine;
		wr(OFS_ADDEND, 32'h80000000);
		ctl(C_FAB | (32'h1 << CTL_FINE));
		tick(1'b1);
		tm(32'h4, 32'h7FFFFFF6);
		tick(1'b1);
		tm(32'h5, 32'h21);
		$display("fine test done");
	endtask
	task automatic t_pps;
		ctl(32'h0);
		wr(OFS_UPDSEC, 32'h9);
		wr(OFS_UPDSUB, 32'h3FFFFFF0);
		ctl(C_INI);
		@(negedge clk);
		chk(ppsOut, 1'b1, "pps first half");
		tick(1'b0);
		@(negedge clk);
		chk(ppsOut, 1'b0, "pps second half");
		$display("pps test done");
	endtask
	task automatic t_tx;
		logic        g;
		logic [63:0] ts;
		mac.send_tx(1'b0);
		repeat (10) @(posedge clk);
		rdc(OFS_STAT, 32'h0);
		mac.send_tx(1'b1);
		rdc(OFS_STAT, 32'h1 << ST_TXPEND);
		mac.back_tx(g, ts);
		chk({g, ts}, {1'b1, TS}, "tx stamp");
		rdc(OFS_STAT, 32'h0);
		mac.send_tx(1'b1);
		mac.send_tx(1'b1); // second delimiter inside the hold-off
		rdc(OFS_STAT, S_TXP | S_TXD);
		wr(OFS_STAT, S_TXD);
		mac.back_tx(g, ts);
		chk({g, ts}, {1'b1, TS}, "tx stamp kept");
		$display("tx capture test done");
	endtask
	task automatic t_rx;
		logic        g;
		logic [63:0] ts;
		repeat (10) @(posedge clk);
		mac.send_rx();
		mac.back_rx(1'b1, g, ts);
		chk({g, ts}, {1'b1, TS}, "rx stamp");
		mac.send_rx(); // too soon after the last capture
		rdc(OFS_STAT, 32'h1 << ST_RXDROP);
		wr(OFS_STAT, 32'h1 << ST_RXDROP);
		rdc(OFS_STAT, 32'h0);
		mac.send_rx();
		mac.back_rx(1'b0, g, ts);
		chk(g, 1'b0, "non-last write-back");
		rdc(OFS_STAT, 32'h1 << ST_RXPEND);
		mac.back_rx(1'b1, g, ts);
		chk({g, ts}, {1'b1, TS}, "last write-back");
		$display("rx capture test done");
	endtask
	task automatic closeOut;
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		refPrim = 1'b0;
		refFab = 1'b0;
		errTotal = 0;
		checkCount = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_load();
		t_coarse();
		t_fine();
		t_pps();
		t_tx();
		t_rx();
		closeOut();
	end
	// hang guard, well past the expected few microseconds
	initial begin
		#50000;
		errTotal++;
		$display("ERROR at %0t: watchdog expired", $time);
		closeOut();
	end
endmodule
`default_nettype wire
